/* rtl/lct_cfg.svh */
`ifndef LCT_CFG_SVH
`define LCT_CFG_SVH

// ==========================================================
// Register byte offsets
`define LCT_OFS_TIMER 12'h0f0
`define LCT_OFS_UPPER_SET 12'h100
`define LCT_OFS_UPPER_CLR 12'h104
`define LCT_OFS_LOWER_SET 12'h108
`define LCT_OFS_LOWER_CLR 12'h10c
`define LCT_OFS_CTRL 12'h1e0
`define LCT_OFS_BUS_ID 12'h1e4

// ==========================================================
// Field positions
`define LCT_SEC_MSB 31
`define LCT_SEC_LSB 25
`define LCT_CYC_MSB 24
`define LCT_CYC_LSB 12
`define LCT_OFF_MSB 11
`define LCT_OFF_LSB 0
`define LCT_CTRL_MASTER 0
`define LCT_CTRL_TMR_EN 1
`define LCT_CTRL_EXT_SEL 2
`define LCT_ALL_BUS_BIT 31

// ==========================================================
// Reset values
`define LCT_MASK_RST 32'h0000_0000
`define LCT_BUS_ID_RST 10'h3ff
`define LCT_TIMER_RST 32'h0000_0000

// ==========================================================
// Timing, local bus and broadcast node
`define LCT_SYS_CLK_KHZ 100000
`define LCT_LINK_CLK_KHZ 24576
`define LCT_OFF_MOD 3072
`define LCT_CYC_MOD 8000
`define LCT_LOCAL_BUS 10'h3ff
`define LCT_BROADCAST_NODE 6'h3f

`endif

/* rtl/lct_pkg.sv */
package lct_pkg;

  typedef struct packed {
    logic [6:0] seconds;
    logic [12:0] cycle;
    logic [11:0] offset;
  } lct_timer_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } lct_sync_t;

  typedef struct packed {
    logic [31:0] mask;
  } lct_mask_t;

  typedef enum logic [1:0] {
    LCT_F_IDLE,
    LCT_F_ACCEPT,
    LCT_F_REJECT
  } lct_fstate_t;

endpackage

/* rtl/lct_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module lct_sync (
  input wire logic mclk_i,   // System clock
  input wire logic rstn_i,   // Sync reset, active low
  input wire logic async_i,  // Pin level
  output logic rise_o        // One-cycle rising edge
);

  lct_pkg::lct_sync_t st, next_st;

  // ==========================================================
  // Two flops, then an edge flop; only s2/s3 feed logic
  always_comb begin
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise_o = st.s2 & ~st.s3;

endmodule

`default_nettype wire

/* rtl/lct_setclr_mask.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lct_cfg.svh"

module lct_setclr_mask #(
  parameter int WIDTH = 32
) (
  input wire logic mclk_i,              // System clock
  input wire logic rstn_i,              // Sync reset, active low
  input wire logic set_i,               // Write-one-to-set strobe
  input wire logic clr_i,               // Write-one-to-clear strobe
  input wire logic [WIDTH-1:0] wdata_i, // Write data
  output logic [WIDTH-1:0] mask_o       // Current mask
);

  initial begin
    if (WIDTH != 32) $error("lct_setclr_mask: WIDTH must be 32");
  end

  lct_pkg::lct_mask_t st, next_st;

  always_comb begin
    next_st = st;
    if (set_i) next_st.mask = st.mask | wdata_i;
    if (clr_i) next_st.mask = st.mask & ~wdata_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st.mask <= `LCT_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign mask_o = st.mask;

endmodule

`default_nettype wire

/* rtl/lct_link_timer_filter.sv */
// Overview of operation
// RULE_01: Offset counts link clocks, wraps at 3072
// RULE_02: Cycle count steps on offset wrap, mod 8000
// RULE_03: Seconds step on cycle wrap, mod 128
// RULE_04: External 8 kHz tick clears offset
// RULE_05: Cycle master sends timer in cycle start
// RULE_06: Non-master loads timer from received start
// RULE_07: Timer free-runs when enabled, missing starts
// RULE_08: Software write loads all fields at once
// RULE_09: Upper mask: set/clear addresses, reads, resets zero
// RULE_10: Filter physical/request-context packets by source bit
// RULE_11: Per-node compare only for local-bus sources
// RULE_12: Remote-bus requests need bit 31 set
// RULE_13: Upper bits 30..0 map nodes 62..32
// RULE_14: Software-writable local bus identifier
// RULE_15: Lower mask filters nodes 0..31 identically
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "lct_cfg.svh"

module lct_link_timer_filter #(
  parameter int SYS_CLK_KHZ = `LCT_SYS_CLK_KHZ,
  parameter int LINK_CLK_KHZ = `LCT_LINK_CLK_KHZ
) (
  input wire logic mclk_i,              // 100 MHz clock
  input wire logic rstn_i,              // Sync reset, active low
  // Register port
  input wire logic [11:0] addr_i,       // Byte address
  input wire logic [31:0] wdata_i,      // Write data
  input wire logic wr_i,                // Write strobe
  input wire logic rd_i,                // Read strobe
  output logic [31:0] rdata_o,          // Read data, cycle after rd_i
  // External cycle clock
  input wire logic ext_cycle_clk_i,     // 8 kHz pin
  // Cycle start packets
  input wire logic cs_rx_valid_i,       // Cycle start received
  input wire logic [31:0] cs_rx_data_i, // Its data field
  input wire logic cs_tx_req_i,         // Link about to send start
  output logic cs_tx_valid_o,           // Data for start packet valid
  output logic [31:0] cs_tx_data_o,     // Data for start packet
  output logic cycle_tick_o,            // Cycle boundary pulse
  // Request filter
  input wire logic req_valid_i,         // Request header present
  input wire logic req_filtered_i,      // Aimed at physical or request ctx
  input wire logic [15:0] req_src_id_i, // Source bus and node
  output logic req_accept_o,            // Acknowledge and queue
  output logic req_reject_o             // Drop without ack
);

  // ==========================================================
  // Elaboration checks
  localparam int NCO_MOD = SYS_CLK_KHZ;
  localparam int NCO_INC = LINK_CLK_KHZ;

  initial begin
    if (NCO_INC <= 0 || NCO_INC > NCO_MOD) begin
      $error("lct_link_timer_filter: link rate must not exceed system rate");
    end
    if (NCO_MOD >= (1 << 17)) begin
      $error("lct_link_timer_filter: system rate too high for accumulator");
    end
    // Field moduli must fit the struct fields
    if (`LCT_OFF_MOD < 2 || `LCT_OFF_MOD > (1 << 12)) begin
      $error("lct_link_timer_filter: offset modulus does not fit its field");
    end
    if (`LCT_CYC_MOD < 2 || `LCT_CYC_MOD > (1 << 13)) begin
      $error("lct_link_timer_filter: cycle modulus does not fit its field");
    end
    if (`LCT_SEC_MSB - `LCT_SEC_LSB != 6 || `LCT_CYC_MSB - `LCT_CYC_LSB != 12) begin
      $error("lct_link_timer_filter: seconds or cycle field layout mismatch");
    end
    if (`LCT_OFF_MSB - `LCT_OFF_LSB != 11 || `LCT_CYC_LSB != `LCT_OFF_MSB + 1) begin
      $error("lct_link_timer_filter: offset field layout mismatch");
    end
  end

  localparam logic [16:0] NCO_MOD_W = 17'(NCO_MOD);
  localparam logic [16:0] NCO_INC_W = 17'(NCO_INC);
  localparam logic [11:0] OFF_LAST = 12'(`LCT_OFF_MOD - 1);
  localparam logic [12:0] CYC_LAST = 13'(`LCT_CYC_MOD - 1);

  // ==========================================================
  // State
  typedef struct packed {
    lct_pkg::lct_timer_t tmr;
    logic [16:0] nco;
    logic master;
    logic tmr_en;
    logic ext_sel;
    logic [9:0] bus_id;
    logic [31:0] rdata;
    logic tx_valid;
    logic [31:0] tx_data;
    logic tick;
    lct_pkg::lct_fstate_t fst;
  } lct_state_t;

  lct_state_t st, next_st;

  // ==========================================================
  // Decoding shared by writes and reads
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Node-bit lookup across both masks
  function automatic logic node_ok(
    input logic [5:0] node,
    input logic [31:0] upper,
    input logic [31:0] lower
  );
    logic r;
    r = 1'b0;
    if (node == `LCT_BROADCAST_NODE) begin
      r = 1'b0;
    end else if (node[5]) begin
      r = upper[node[4:0]];
    end else begin
      r = lower[node[4:0]];
    end
    node_ok = r;
  endfunction

  // ==========================================================
  // Set/clear masks
  // Both halves share one set/clear block; only the decode differs
  logic [31:0] upper_mask;
  logic [31:0] lower_mask;

  lct_setclr_mask #(
    .WIDTH(32)
  ) u_upper (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i(wr_i && hit(addr_i, `LCT_OFS_UPPER_SET)), // [RULE_09]
    .clr_i(wr_i && hit(addr_i, `LCT_OFS_UPPER_CLR)), // [RULE_09]
    .wdata_i(wdata_i),
    .mask_o(upper_mask)
  );

  lct_setclr_mask #(
    .WIDTH(32)
  ) u_lower (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i(wr_i && hit(addr_i, `LCT_OFS_LOWER_SET)), // [RULE_15]
    .clr_i(wr_i && hit(addr_i, `LCT_OFS_LOWER_CLR)), // [RULE_15]
    .wdata_i(wdata_i),
    .mask_o(lower_mask)
  );

  // ==========================================================
  // External 8 kHz tick
  logic ext_rise;

  lct_sync u_ext (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .async_i(ext_cycle_clk_i),
    .rise_o(ext_rise)
  );

  // ==========================================================
  // Next state
  logic [17:0] nco_sum;
  logic link_tick;
  logic off_wrap;
  logic cyc_wrap;
  logic [5:0] src_node;
  logic [9:0] src_bus;
  logic src_local;
  logic pass;
  logic [31:0] tmr_word;

  always_comb begin
    next_st = st;
    nco_sum = 18'(st.nco) + 18'(NCO_INC_W);
    link_tick = 1'b0;
    off_wrap = 1'b0;
    cyc_wrap = 1'b0;
    tmr_word = st.tmr;
    src_node = req_src_id_i[5:0];
    src_bus = req_src_id_i[15:6];
    src_local = 1'b0;
    pass = 1'b0;
    next_st.tick = 1'b0;
    next_st.tx_valid = 1'b0;

    // Fractional divider: 24.576 MHz ticks from the system clock
    // Remainder stays in the accumulator, so the long-run rate is exact
    if (nco_sum >= 18'(NCO_MOD_W)) begin
      next_st.nco = 17'(nco_sum - 18'(NCO_MOD_W));
      link_tick = 1'b1;
    end else begin
      next_st.nco = nco_sum[16:0];
    end

    // Free-running count, kept even when starts go missing
    if (st.tmr_en) begin // [RULE_07]
      if (st.ext_sel) begin
        // External tick owns the cycle boundary; offset stops at its top
        if (ext_rise) begin // [RULE_04]
          off_wrap = 1'b1;
          next_st.tmr.offset = '0;
        end else if (link_tick && st.tmr.offset < OFF_LAST) begin
          next_st.tmr.offset = st.tmr.offset + 12'h001;
        end
      end else if (link_tick) begin
        if (st.tmr.offset >= OFF_LAST) begin // [RULE_01]
          off_wrap = 1'b1;
          next_st.tmr.offset = '0;
        end else begin
          next_st.tmr.offset = st.tmr.offset + 12'h001; // [RULE_01]
        end
      end
      if (off_wrap) begin
        next_st.tick = 1'b1;
        if (st.tmr.cycle >= CYC_LAST) begin // [RULE_02]
          cyc_wrap = 1'b1;
          next_st.tmr.cycle = '0;
        end else begin
          next_st.tmr.cycle = st.tmr.cycle + 13'h0001; // [RULE_02]
        end
      end
      if (cyc_wrap) begin
        next_st.tmr.seconds = st.tmr.seconds + 7'h01; // [RULE_03]
      end
    end

    // Received start resynchronises a non-master node
    // A software write in the same cycle still wins, below
    if (cs_rx_valid_i && !st.master) begin
      next_st.tmr = cs_rx_data_i; // [RULE_06]
    end

    // Master hands the live timer to the start packet
    if (cs_tx_req_i && st.master) begin
      next_st.tx_valid = 1'b1;
      next_st.tx_data = tmr_word; // [RULE_05]
    end

    // ==========================================================
    // Register writes, software wins over hardware updates
    if (wr_i) begin
      if (hit(addr_i, `LCT_OFS_TIMER)) begin
        next_st.tmr = wdata_i; // [RULE_08]
      end
      if (hit(addr_i, `LCT_OFS_CTRL)) begin
        next_st.master = wdata_i[`LCT_CTRL_MASTER];
        next_st.tmr_en = wdata_i[`LCT_CTRL_TMR_EN];
        next_st.ext_sel = wdata_i[`LCT_CTRL_EXT_SEL];
      end
      if (hit(addr_i, `LCT_OFS_BUS_ID)) begin
        next_st.bus_id = wdata_i[9:0]; // [RULE_14]
      end
    end

    // ==========================================================
    // Register reads, data in the next cycle only
    next_st.rdata = '0;
    if (rd_i) begin
      if (hit(addr_i, `LCT_OFS_TIMER)) begin
        next_st.rdata = tmr_word;
      end else if (hit(addr_i, `LCT_OFS_UPPER_SET) ||
                   hit(addr_i, `LCT_OFS_UPPER_CLR)) begin
        next_st.rdata = upper_mask; // [RULE_09]
      end else if (hit(addr_i, `LCT_OFS_LOWER_SET) ||
                   hit(addr_i, `LCT_OFS_LOWER_CLR)) begin
        next_st.rdata = lower_mask;
      end else if (hit(addr_i, `LCT_OFS_CTRL)) begin
        next_st.rdata[`LCT_CTRL_MASTER] = st.master;
        next_st.rdata[`LCT_CTRL_TMR_EN] = st.tmr_en;
        next_st.rdata[`LCT_CTRL_EXT_SEL] = st.ext_sel;
      end else if (hit(addr_i, `LCT_OFS_BUS_ID)) begin
        next_st.rdata[9:0] = st.bus_id;
      end else begin
        next_st.rdata = '0;
      end
    end

    // ==========================================================
    // Request filter
    // Bus 3FFh always means this node's own bus
    src_local = (src_bus == `LCT_LOCAL_BUS) || (src_bus == st.bus_id); // [RULE_14]
    if (!req_filtered_i) begin
      pass = 1'b1;
    end else if (src_local) begin
      // Upper bit n stands for node n+32
      pass = node_ok(src_node, upper_mask, lower_mask); // [RULE_11] [RULE_13] [RULE_15]
    end else begin
      pass = upper_mask[`LCT_ALL_BUS_BIT]; // [RULE_12]
    end

    // Every request gets one answer; the state only shapes the pulse
    case (st.fst)
      lct_pkg::LCT_F_IDLE,
      lct_pkg::LCT_F_ACCEPT,
      lct_pkg::LCT_F_REJECT: begin
        if (req_valid_i) begin
          next_st.fst = pass ? lct_pkg::LCT_F_ACCEPT : lct_pkg::LCT_F_REJECT; // [RULE_10]
        end else begin
          next_st.fst = lct_pkg::LCT_F_IDLE;
        end
      end
      default: begin
        next_st.fst = lct_pkg::LCT_F_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st.tmr <= `LCT_TIMER_RST;
      st.nco <= '0;
      st.master <= 1'b0;
      st.tmr_en <= 1'b0;
      st.ext_sel <= 1'b0;
      st.bus_id <= `LCT_BUS_ID_RST;
      st.rdata <= '0;
      st.tx_valid <= 1'b0;
      st.tx_data <= '0;
      st.tick <= 1'b0;
      st.fst <= lct_pkg::LCT_F_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // Tick and start packet outputs leave straight from flops; accept and reject are decoded from st.fst
  assign rdata_o = st.rdata;
  assign cs_tx_valid_o = st.tx_valid;
  assign cs_tx_data_o = st.tx_data;
  assign cycle_tick_o = st.tick;
  assign req_accept_o = (st.fst == lct_pkg::LCT_F_ACCEPT);
  assign req_reject_o = (st.fst == lct_pkg::LCT_F_REJECT);

endmodule

`default_nettype wire

/* testbench/lct_link_timer_filter_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checker
module lct_chk (
  input wire logic mclk_i,              // Clock
  input wire logic rstn_i,              // Reset
  input wire logic rd_i,                // Read strobe
  input wire logic [31:0] rdata_o,      // Read data
  input wire logic cs_tx_req_i,         // Start request
  input wire logic cs_tx_valid_o,       // Start valid
  input wire logic [31:0] cs_tx_data_o, // Start data
  input wire logic cycle_tick_o,        // Cycle pulse
  input wire logic req_valid_i,         // Request
  input wire logic req_filtered_i,      // Filter applies
  input wire logic [15:0] req_src_id_i, // Source
  input wire logic req_accept_o,        // Accept
  input wire logic req_reject_o         // Reject
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_tx_cause: assert property (cs_tx_valid_o |-> $past(cs_tx_req_i))
    else $error("start valid without request");
  a_tx_hold: assert property (!$past(cs_tx_req_i) |-> $stable(cs_tx_data_o))
    else $error("start data moved without request");
  a_one_answer: assert property (req_valid_i |=> req_accept_o ^ req_reject_o)
    else $error("request not answered once");
  a_no_spurious: assert property ((req_accept_o || req_reject_o) |-> $past(req_valid_i))
    else $error("answer without request");
  a_unfilt_pass: assert property (req_valid_i && !req_filtered_i |=> req_accept_o)
    else $error("unfiltered request dropped");
  a_bcast_drop: assert property (req_valid_i && req_filtered_i &&
    req_src_id_i == 16'hffff |=> req_reject_o)
    else $error("local node 63 accepted");
  a_tick_single: assert property (cycle_tick_o |=> !cycle_tick_o)
    else $error("cycle pulse longer than one cycle");
endmodule
bind lct_link_timer_filter lct_chk u_lct_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .cs_tx_req_i(cs_tx_req_i), .cs_tx_valid_o(cs_tx_valid_o),
  .cs_tx_data_o(cs_tx_data_o), .cycle_tick_o(cycle_tick_o), .req_valid_i(req_valid_i),
  .req_filtered_i(req_filtered_i), .req_src_id_i(req_src_id_i),
  .req_accept_o(req_accept_o), .req_reject_o(req_reject_o));
`default_nettype wire

/* testbench/lct_node.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Remote nodes behind the PHY
module lct_node (
  input wire logic mclk_i,          // Clock
  input wire logic tx_valid_i,      // Start valid
  input wire logic [31:0] tx_data_i, // Start data
  input wire logic acc_i,           // Accept
  input wire logic rej_i,           // Reject
  output logic rx_valid_o,          // Start received
  output logic [31:0] rx_data_o,    // Its data
  output logic tx_req_o,            // Start wanted
  output logic rq_valid_o,          // Request
  output logic rq_filt_o,           // Filter applies
  output logic [15:0] rq_src_o      // Source
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 32'h0000_0000;
    tx_req_o = 1'b0;
    rq_valid_o = 1'b0;
    rq_filt_o = 1'b0;
    rq_src_o = 16'h0000;
  end
  // Released lines show the inverse so stale values never match
  task automatic send_cs(input logic [31:0] d);
    @(posedge mclk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
  endtask
  task automatic want_cs(output logic v, output logic [31:0] d);
    @(posedge mclk_i);
    tx_req_o <= 1'b1;
    @(posedge mclk_i);
    tx_req_o <= 1'b0;
    #1;
    v = tx_valid_i;
    d = tx_data_i;
  endtask
  task automatic send_rq(input logic f, input logic [15:0] s, output logic a, output logic r);
    @(posedge mclk_i);
    rq_valid_o <= 1'b1;
    rq_filt_o <= f;
    rq_src_o <= s;
    @(posedge mclk_i);
    rq_valid_o <= 1'b0;
    rq_filt_o <= ~f;
    rq_src_o <= ~s;
    #1;
    a = acc_i;
    r = rej_i;
  endtask
endmodule
`default_nettype wire

/* testbench/test_lct_link_timer_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module test_lct_link_timer_filter;
  logic mclk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ext_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0000_0000, rdata_o, tx_data, rx_data, d;
  logic rx_v, tx_req, tx_v, rq_v, rq_f, acc, rej, tick;
  logic [15:0] rq_s;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  initial forever #5 mclk_i = ~mclk_i;

  // Slow link tick keeps the timer easy to follow
  lct_link_timer_filter #(.SYS_CLK_KHZ(2), .LINK_CLK_KHZ(1)) u_lct_link_timer_filter (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ext_cycle_clk_i(ext_i), .cs_rx_valid_i(rx_v),
    .cs_rx_data_i(rx_data), .cs_tx_req_i(tx_req), .cs_tx_valid_o(tx_v),
    .cs_tx_data_o(tx_data), .cycle_tick_o(tick), .req_valid_i(rq_v),
    .req_filtered_i(rq_f), .req_src_id_i(rq_s), .req_accept_o(acc), .req_reject_o(rej));
  lct_node u_lct_node (.mclk_i(mclk_i), .tx_valid_i(tx_v), .tx_data_i(tx_data),
    .acc_i(acc), .rej_i(rej), .rx_valid_o(rx_v), .rx_data_o(rx_data), .tx_req_o(tx_req),
    .rq_valid_o(rq_v), .rq_filt_o(rq_f), .rq_src_o(rq_s));

  // ==========================================
  // Bus tasks and checks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic req(input logic f, input logic [15:0] s, input logic e);
    logic a, r;
    u_lct_node.send_rq(f, s, a, r);
    chk("accept", {31'h0, e}, {31'h0, a});
    chk("reject", {31'h0, ~e}, {31'h0, r});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rd(12'h0f0, d);
    chk("timer reset", 32'h0000_0000, d);
    rd(12'h100, d);
    chk("mask reset", 32'h0000_0000, d);
    wr(12'h100, 32'h8000_0001);
    wr(12'h100, 32'h4000_0000);
    rd(12'h104, d);
    chk("mask set", 32'hc000_0001, d);
    wr(12'h104, 32'h4000_0000);
    rd(12'h100, d);
    chk("mask clear", 32'h8000_0001, d);
    rd(12'h0a4, d);
    chk("unmapped", 32'h0000_0000, d);
  endtask
  task automatic t_filter();
    req(1'b1, 16'hffe0, 1'b1);
    req(1'b1, 16'hffe1, 1'b0);
    req(1'b1, 16'hfffe, 1'b0);
    wr(12'h100, 32'h4000_0000);
    req(1'b1, 16'hfffe, 1'b1);
    req(1'b1, 16'h0161, 1'b1);
    req(1'b0, 16'hffe1, 1'b1);
    wr(12'h104, 32'h8000_0000);
    req(1'b1, 16'h0161, 1'b0);
    wr(12'h1e4, 32'h0000_0005);
    req(1'b1, 16'h0160, 1'b1);
    wr(12'h108, 32'h0000_0008);
    req(1'b1, 16'hffc3, 1'b1);
    req(1'b1, 16'hffc4, 1'b0);
    wr(12'h10c, 32'h0000_0008);
    rd(12'h108, d);
    chk("lower clear", 32'h0000_0000, d);
    rd(12'h1e4, d);
    chk("bus id", 32'h0000_0005, d);
    wr(12'h100, 32'h8000_0000);
    req(1'b1, 16'hffff, 1'b0);
  endtask
  task automatic t_count(input logic [6:0] s);
    int n_tick = 0;
    wr(12'h1e0, 32'h0000_0002);
    wr(12'h0f0, {s, 13'd7999, 12'd3070});
    repeat (40) begin
      @(posedge mclk_i);
      #1;
      if (tick === 1'b1) begin
        n_tick++;
      end
    end
    chk("cycle ticks", 32'h0000_0001, n_tick);
    rd(12'h0f0, d);
    chk("seconds", {25'h0, s + 7'd1}, {25'h0, d[31:25]});
    chk("cycle", 32'h0000_0000, {19'h0, d[24:12]});
    chk("offset low", 32'h0000_0001, {31'h0, d[11:0] < 12'd32});
  endtask
  task automatic t_ext();
    wr(12'h1e0, 32'h0000_0006);
    rd(12'h1e0, d);
    chk("control", 32'h0000_0006, d);
    wr(12'h0f0, {7'd0, 13'd10, 12'd3000});
    @(posedge mclk_i);
    ext_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    ext_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rd(12'h0f0, d);
    chk("ext cycle", 32'h0000_000b, {19'h0, d[24:12]});
    chk("ext offset", 32'h0000_0001, {31'h0, d[11:0] < 12'd16});
  endtask
  task automatic t_cs();
    logic v;
    wr(12'h1e0, 32'h0000_0001);
    wr(12'h0f0, 32'h1234_5678);
    u_lct_node.want_cs(v, d);
    chk("tx valid", 32'h0000_0001, {31'h0, v});
    chk("tx data", 32'h1234_5678, d);
    u_lct_node.send_cs(32'h0abc_d123);
    rd(12'h0f0, d);
    chk("master keeps", 32'h1234_5678, d);
    wr(12'h1e0, 32'h0000_0000);
    u_lct_node.send_cs(32'h0abc_d123);
    rd(12'h0f0, d);
    chk("rx load", 32'h0abc_d123, d);
    u_lct_node.want_cs(v, d);
    chk("tx refused", 32'h0000_0000, {31'h0, v});
  endtask

  // ==========================================
  // Run control
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_filter();
    t_count(7'd5);
    t_count(7'd127);
    t_ext();
    t_cs();
    finish_test();
  end
endmodule
`default_nettype wire
